// *** ppf_frame_out.sv ***
`timescale 1ns/100ps
`default_nettype none
module ppf_frame_out (
    input  wire logic                        ref_clk,
    input  wire logic                        rst_n,
    input  wire logic                        ce,
    input  wire logic                        pix_clk_pin,
    input  wire logic                        frame_start,
    input  wire logic [ppf_pkg::CNT_W-1:0]   frame_overhead_interval,
    input  wire logic [ppf_pkg::CNT_W-1:0]   row_overhead_interval,
    input  wire logic [ppf_pkg::ROW_W-1:0]   black_rows,
    input  wire ppf_pkg::ppf_geom_t          geom,
    input  wire logic                        win_b_en,
    input  wire logic                        black_row_frame_strobe_en,
    input  wire logic                        black_row_line_strobe_en,
    input  wire ppf_pkg::ppf_sub_t           sub_mode,
    input  wire logic                        crc_seed_ones,
    input  wire logic                        train_wr,
    input  wire logic [ppf_pkg::PIX_W-1:0]   train_word,
    input  wire logic                        kern_valid,
    output logic                             kern_ready,
    input  wire ppf_pkg::ppf_kernel_t        kern_data,
    output logic                             line_req_valid,
    output ppf_pkg::ppf_line_t               line_req,
    output logic                             pix_clk_out,
    output logic [ppf_pkg::PIX_W-1:0]        pix_data,
    output logic                             frame_valid,
    output logic                             line_valid,
    output logic                             busy
);
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_FOT  = 6'h02,
        S_REQ  = 6'h04,
        S_PIX  = 6'h08,
        S_CRC  = 6'h10,
        S_ROT  = 6'h20
    } ppf_state_t;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [ppf_pkg::PIX_W-1:0] crc_next(
        input logic [ppf_pkg::PIX_W-1:0] c,
        input logic [ppf_pkg::PIX_W-1:0] d);
        logic [ppf_pkg::PIX_W-1:0] r;
        logic                      fb;
        r = c;
        for (int i = ppf_pkg::PIX_W - 1; i >= 0; i--) begin
            fb = r[ppf_pkg::PIX_W-1] ^ d[i];
            r  = {r[ppf_pkg::PIX_W-2:0], 1'b0};
            if (fb) begin
                r = r ^ ppf_pkg::CRC_POLY;
            end
        end
        return r;
    endfunction : crc_next

    function automatic logic [3:0] pix_pos(
        input ppf_pkg::ppf_sub_t m,
        input logic              odd,
        input logic [2:0]        i);
        logic [3:0] p;
        p = {1'b0, i};
        if (m == ppf_pkg::SUB_MONO) begin
            p = {i, 1'b0};
        end else if (m == ppf_pkg::SUB_COLOR) begin
            p = {i[2:1], 1'b0, i[0]};
        end else if (odd) begin
            p = {1'b0, ppf_pkg::IDX_LAST - i};
        end
        return p;
    endfunction : pix_pos

    function automatic logic in_range(
        input logic [ppf_pkg::ROW_W-1:0] r,
        input logic [ppf_pkg::ROW_W-1:0] lo,
        input logic [ppf_pkg::ROW_W-1:0] hi);
        return (r >= lo) && (r <= hi);
    endfunction : in_range

    ////////////////////////////////////////////////////////////////////////
    // Link clock sampling
    logic pclk_s1_ff;
    logic pclk_s2_ff;
    logic pclk_s3_ff;
    logic tick;

    // Pin is asynchronous to ref_clk, hence two stages before use
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pclk_s1_ff <= 1'b0;
            pclk_s2_ff <= 1'b0;
            pclk_s3_ff <= 1'b0;
        end else if (ce) begin
            pclk_s1_ff <= pix_clk_pin;
            pclk_s2_ff <= pclk_s1_ff;
            pclk_s3_ff <= pclk_s2_ff;
        end
    end

    assign tick = ce && pclk_s2_ff && !pclk_s3_ff;

    ////////////////////////////////////////////////////////////////////////
    // Kernel buffer
    ppf_pkg::ppf_kernel_t kern_q;
    logic                 kern_q_valid;
    logic                 pop;

    ppf_fifo #(
        .WIDTH (ppf_pkg::KER_W),
        .DEPTH (ppf_pkg::FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .rst_n     (rst_n),
        .ce        (ce),
        .in_valid  (kern_valid),
        .in_ready  (kern_ready),
        .in_data   (kern_data),
        .out_valid (kern_q_valid),
        .out_ready (pop),
        .out_data  (kern_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer state
    ppf_state_t                  st_ff;
    logic                        start_pend_ff;
    logic [ppf_pkg::CNT_W-1:0]   cnt_ff;
    logic [ppf_pkg::ROW_W-1:0]   black_left_ff;
    logic [ppf_pkg::ROW_W-1:0]   row_ff;
    logic [2:0]                  idx_ff;
    logic [ppf_pkg::PIX_W-1:0]   crc_ff;
    logic [ppf_pkg::PIX_W-1:0]   train_ff;
    logic                        blk_line_ff;
    logic                        last_line_ff;
    logic                        lv_cover_ff;
    logic                        pix_ok;
    logic                        in_a;
    logic                        in_b;
    logic                        is_black;
    logic                        issue;
    logic                        fv_cover;
    logic [ppf_pkg::ROW_W-1:0]   first_row;
    logic [ppf_pkg::ROW_W-1:0]   end_row;
    logic [3:0]                  pos;
    logic [ppf_pkg::PIX_W-1:0]   cur_pix;
    logic [ppf_pkg::PIX_W-1:0]   seed;

    assign first_row = (win_b_en && geom.b_first < geom.a_first)
                     ? geom.b_first : geom.a_first;
    assign end_row   = (win_b_en && geom.b_last > geom.a_last)
                     ? geom.b_last : geom.a_last;
    assign in_a      = in_range(row_ff, geom.a_first, geom.a_last);
    assign in_b      = win_b_en && in_range(row_ff, geom.b_first, geom.b_last);
    assign is_black  = (black_left_ff != '0);
    assign issue     = tick && (st_ff == S_REQ)
                     && (is_black || (row_ff <= end_row && (in_a || in_b)));
    assign fv_cover  = is_black ? black_row_frame_strobe_en : 1'b1;
    assign seed      = crc_seed_ones ? ppf_pkg::CRC_SEED_ONES
                                     : ppf_pkg::CRC_SEED_ZERO;
    assign pix_ok    = tick && (st_ff == S_PIX) && kern_q_valid;
    assign pos       = pix_pos(sub_mode, kern_q.odd, idx_ff);
    assign cur_pix   = kern_q.pix[pos*ppf_pkg::PIX_W +: ppf_pkg::PIX_W];
    // one kernel leaves after its eighth word
    assign pop       = pix_ok && (idx_ff == ppf_pkg::IDX_LAST);

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            start_pend_ff <= 1'b0;
        end else if (ce) begin
            if (frame_start) begin
                start_pend_ff <= 1'b1;
            end else if (tick && st_ff == S_IDLE) begin
                start_pend_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            train_ff <= ppf_pkg::TRAIN_RST;
        end else if (ce && train_wr) begin
            train_ff <= train_word;
        end
    end

    // frame overhead, then lines in row order
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_ff         <= S_IDLE;
            cnt_ff        <= '0;
            black_left_ff <= '0;
            row_ff        <= '0;
            idx_ff        <= '0;
        end else if (tick) begin
            unique case (st_ff)
                S_IDLE: if (start_pend_ff) begin
                    st_ff         <= S_FOT;
                    cnt_ff        <= frame_overhead_interval;
                    black_left_ff <= black_rows;
                    row_ff        <= first_row;
                end
                S_FOT: begin
                    if (cnt_ff == '0) begin
                        st_ff <= S_REQ;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                S_REQ: begin
                    idx_ff <= '0;
                    if (is_black) begin
                        black_left_ff <= black_left_ff - 1'b1;
                        st_ff         <= S_PIX;
                    end else if (row_ff > end_row) begin
                        st_ff <= S_IDLE;
                    end else begin
                        // Rows outside both windows are skipped
                        row_ff <= row_ff + 1'b1;
                        if (in_a || in_b) begin
                            st_ff <= S_PIX;
                        end
                    end
                end
                S_PIX: if (kern_q_valid) begin
                    idx_ff <= idx_ff + 1'b1;
                    if (pop && kern_q.last) begin
                        st_ff <= S_CRC;
                    end
                end
                S_CRC: begin
                    st_ff  <= S_ROT;
                    cnt_ff <= row_overhead_interval;
                end
                S_ROT: begin
                    if (cnt_ff == '0) begin
                        st_ff <= S_REQ;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
            endcase
        end
    end

    // Per-line attributes latched at issue
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            blk_line_ff  <= 1'b0;
            last_line_ff <= 1'b0;
            lv_cover_ff  <= 1'b0;
        end else if (issue) begin
            blk_line_ff  <= is_black;
            last_line_ff <= !is_black && (row_ff == end_row);
            lv_cover_ff  <= is_black ? black_row_line_strobe_en : 1'b1;
        end
    end

    // seed at line start, pixel words only
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            crc_ff <= ppf_pkg::CRC_SEED_ZERO;
        end else if (issue) begin
            crc_ff <= seed;
        end else if (pix_ok) begin
            crc_ff <= crc_next(crc_ff, cur_pix);
        end
    end

    // Window request to the array side; never reaches the output
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            line_req_valid <= 1'b0;
            line_req       <= '0;
        end else if (ce) begin
            line_req_valid <= issue;
            if (issue) begin
                line_req.row   <= is_black ? '0 : row_ff;
                line_req.win_a <= !is_black && in_a;
                line_req.win_b <= !is_black && in_b;
                line_req.black <= is_black;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output word and strobes
    // registered pins, strobes low in reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pix_clk_out <= 1'b0;
            busy        <= 1'b0;
        end else if (ce) begin
            pix_clk_out <= pclk_s2_ff;
            busy        <= (st_ff != S_IDLE);
        end
    end

    // frame strobe spans first covered line to last checksum
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            frame_valid <= 1'b0;
        end else if (issue && fv_cover) begin
            frame_valid <= 1'b1;
        end else if (tick && st_ff == S_ROT && last_line_ff) begin
            // One word late, so the last checksum is still framed
            frame_valid <= 1'b0;
        end else if (tick && st_ff == S_IDLE) begin
            frame_valid <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pix_data   <= ppf_pkg::TRAIN_RST;
            line_valid <= 1'b0;
        end else if (tick) begin
            // Buffer underrun drops the strobe rather than send stale data
            line_valid <= pix_ok && lv_cover_ff;
            if (pix_ok) begin
                pix_data <= cur_pix;
            end else if (st_ff == S_CRC) begin
                pix_data <= crc_ff;
            end else begin
                pix_data <= train_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence line_close_s;
        tick && pop && kern_q.last;
    endsequence

    sequence crc_emit_s;
        tick && st_ff == S_CRC;
    endsequence

    reset_strobes_a: assert property (@(posedge ref_clk)
        !rst_n |=> !frame_valid && !line_valid)
        else $error("strobe high after reset");

    tick_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !tick |=> $stable(pix_data) && $stable(line_valid))
        else $error("output changed without clock edge");

    crc_word_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        crc_emit_s |=> pix_data == $past(crc_ff) && !line_valid)
        else $error("checksum word wrong");

    line_end_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        line_close_s |=> st_ff == S_CRC)
        else $error("line did not close into checksum");

    image_framed_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        line_valid && !blk_line_ff |-> frame_valid)
        else $error("image pixel outside frame strobe");

    black_lv_mute_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick && blk_line_ff && !black_row_line_strobe_en
        |=> !line_valid)
        else $error("black line strobed while disabled");

    black_fv_mute_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(frame_valid) && !black_row_frame_strobe_en
        |-> !$past(is_black))
        else $error("frame strobe raised on black line");

    idle_train_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        tick && (st_ff == S_ROT || st_ff == S_FOT)
        |=> pix_data == $past(train_ff))
        else $error("idle word not training word");

    lv_in_pix_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(line_valid) |-> $past(st_ff) == S_PIX)
        else $error("line strobe outside pixel phase");
endmodule : ppf_frame_out
`default_nettype wire

// *** ppf_pkg.sv ***
`default_nettype none
package ppf_pkg;
    localparam int PIX_W    = 10;
    localparam int KER_PIX  = 8;
    localparam int MRG_PIX  = 16;
    localparam int ROW_W    = 11;
    localparam int CNT_W    = 16;
    localparam int FIFO_DEPTH = 8;

    // Line checksum x^10+x^9+x^6+x^3+x^2+x+1, x^10 implicit
    localparam logic [PIX_W-1:0] CRC_POLY      = 10'h24F;
    localparam logic [PIX_W-1:0] CRC_SEED_ZERO = 10'h000;
    localparam logic [PIX_W-1:0] CRC_SEED_ONES = 10'h3FF;
    localparam logic [PIX_W-1:0] TRAIN_RST     = 10'h3A6;
    localparam logic [2:0]       IDX_LAST      = 3'h7;

    typedef enum logic [1:0] {
        SUB_NONE  = 2'h0,
        SUB_MONO  = 2'h1,
        SUB_COLOR = 2'h2
    } ppf_sub_t;

    // One kernel; without subsampling only pixels 0..7 are used
    typedef struct packed {
        logic [MRG_PIX*PIX_W-1:0] pix;
        logic                     odd;
        logic                     last;
    } ppf_kernel_t;

    typedef struct packed {
        logic [ROW_W-1:0] row;
        logic             win_a;
        logic             win_b;
        logic             black;
    } ppf_line_t;

    typedef struct packed {
        logic [ROW_W-1:0] a_first;
        logic [ROW_W-1:0] a_last;
        logic [ROW_W-1:0] b_first;
        logic [ROW_W-1:0] b_last;
    } ppf_geom_t;

    localparam int KER_W = $bits(ppf_kernel_t);
endpackage : ppf_pkg
`default_nettype wire

// *** ppf_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module ppf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      cnt_ff;
    logic             full_ff;
    logic             push;
    logic             pop;
    logic [AW:0]      nxt_cnt;

    assign push      = ce && in_valid && !full_ff;
    assign pop       = ce && out_ready && (cnt_ff != '0);
    assign out_valid = (cnt_ff != '0);
    assign out_data  = mem[rd_ptr_ff];
    assign nxt_cnt   = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // Full is a flop so push is gated without a long path
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff    <= '0;
            full_ff   <= 1'b0;
            in_ready  <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr_ff <= AW'((wr_ptr_ff + 1'b1) % DEPTH);
            end
            if (pop) begin
                rd_ptr_ff <= AW'((rd_ptr_ff + 1'b1) % DEPTH);
            end
            cnt_ff  <= nxt_cnt;
            full_ff <= (nxt_cnt == FULL_CNT);
            // Ready is its own flop so the port leaves a register
            in_ready <= (nxt_cnt != FULL_CNT);
        end
    end

    fifo_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (cnt_ff <= FULL_CNT) && (full_ff == (cnt_ff == FULL_CNT)))
        else $error("fifo count out of range");
endmodule : ppf_fifo
`default_nettype wire

// *** ppf_rx_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module ppf_rx_model (
    input  wire logic                      pix_clk,
    input  wire logic [ppf_pkg::PIX_W-1:0] pix_data,
    input  wire logic                      frame_valid,
    input  wire logic                      line_valid
);
    logic [ppf_pkg::PIX_W-1:0] pix_q[$];
    logic [ppf_pkg::PIX_W-1:0] crc_q[$];
    int   fv_n = 0;
    int   lv_n = 0;
    logic lv_d = 1'b0;

    // Sample mid-word, away from the launching edge
    always @(negedge pix_clk) begin
        if (line_valid === 1'b1) pix_q.push_back(pix_data);
        if (lv_d && line_valid === 1'b0) crc_q.push_back(pix_data);
        if (frame_valid === 1'b1) fv_n++;
        if (line_valid === 1'b1) lv_n++;
        lv_d = (line_valid === 1'b1);
    end
endmodule : ppf_rx_model
`default_nettype wire

// *** parallel_pixel_frame_output_test.sv ***
`timescale 1ns/100ps
`default_nettype none
module parallel_pixel_frame_output_test;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic pix_clk_pin = 1'b0;
    logic frame_start = 1'b0;
    logic win_b_en = 1'b0;
    logic black_row_frame_strobe_en = 1'b0;
    logic black_row_line_strobe_en = 1'b0;
    logic crc_seed_ones = 1'b0;
    logic train_wr = 1'b0;
    logic kern_valid = 1'b0;
    logic refused = 1'b0;
    logic [ppf_pkg::PIX_W-1:0] train_word = 10'h000;
    logic [ppf_pkg::ROW_W-1:0] black_rows = 11'h000;
    ppf_pkg::ppf_geom_t   geom = '0;
    ppf_pkg::ppf_sub_t    sub_mode = ppf_pkg::SUB_NONE;
    ppf_pkg::ppf_kernel_t kern_data = '0;
    ppf_pkg::ppf_line_t   line_req;
    logic kern_ready, line_req_valid, pix_clk_out;
    logic frame_valid, line_valid, busy;
    logic [ppf_pkg::PIX_W-1:0] pix_data;
    logic [ppf_pkg::PIX_W-1:0] exp_q[$];
    logic [ppf_pkg::PIX_W-1:0] ecrc_q[$];
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;

    ppf_frame_out ppf_frame_out_inst (
        .ref_clk, .rst_n, .ce(1'b1), .pix_clk_pin, .frame_start,
        .frame_overhead_interval(16'h0001), .row_overhead_interval(16'h0001),
        .black_rows, .geom, .win_b_en, .black_row_frame_strobe_en,
        .black_row_line_strobe_en, .sub_mode, .crc_seed_ones, .train_wr,
        .train_word, .kern_valid, .kern_ready, .kern_data, .line_req_valid,
        .line_req, .pix_clk_out, .pix_data, .frame_valid, .line_valid, .busy
    );
    ppf_rx_model ppf_rx_model_inst (
        .pix_clk(pix_clk_out), .pix_data, .frame_valid, .line_valid
    );

    ////////////////////////////////////////////////////////////////////
    always #5 ref_clk = ~ref_clk;
    // Offset so pin edges never line up with ref_clk
    initial begin
        #3;
        forever #80 pix_clk_pin = ~pix_clk_pin;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 30000) begin
            n_fail++;
            conclude();
        end
    end

    function automatic logic [9:0] crc_step(input logic [9:0] c,
                                            input logic [9:0] d);
        for (int b = 9; b >= 0; b--)
            c = {c[8:0], 1'b0} ^ ((c[9] ^ d[b]) ? ppf_pkg::CRC_POLY : 10'h000);
        return c;
    endfunction : crc_step

    function automatic int pos(input int i, input logic odd);
        case (sub_mode)
            ppf_pkg::SUB_MONO:  return 2 * i;
            ppf_pkg::SUB_COLOR: return 4 * (i / 2) + i % 2;
            default:            return odd ? 7 - i : i;
        endcase
    endfunction : pos

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic run_frame(input int nl, input int nk);
        logic [9:0] c;
        logic [9:0] w;
        int r;
        exp_q.delete();
        ecrc_q.delete();
        ppf_rx_model_inst.pix_q.delete();
        ppf_rx_model_inst.crc_q.delete();
        ppf_rx_model_inst.fv_n = 0;
        ppf_rx_model_inst.lv_n = 0;
        frame_start = 1'b1;
        @(negedge ref_clk);
        frame_start = 1'b0;
        for (int l = 0; l < nl; l++) begin
            while (line_req_valid !== 1'b1) @(negedge ref_clk);
            r = l - int'(black_rows);
            if (r < 0) chk("black", 16'(line_req.black), 16'h0001);
            else chk("line", 16'(line_req),
                     16'({r[10:0], r < 2, win_b_en && r > 0, 1'b0}));
            c = crc_seed_ones ? ppf_pkg::CRC_SEED_ONES : ppf_pkg::CRC_SEED_ZERO;
            for (int k = 0; k < nk; k++) begin
                for (int p = 0; p < 16; p++)
                    kern_data.pix[10*p+:10] = 10'(l * 160 + k * 16 + p + 1);
                kern_data.odd = k[0];
                kern_data.last = (k == nk - 1);
                kern_valid = 1'b1;
                // Full FIFO must hold the kernel back
                while (kern_ready !== 1'b1) begin
                    refused = 1'b1;
                    @(negedge ref_clk);
                end
                @(negedge ref_clk);
                for (int i = 0; i < 8; i++) begin
                    w = 10'(l * 160 + k * 16 + pos(i, k[0]) + 1);
                    exp_q.push_back(w);
                    c = crc_step(c, w);
                end
            end
            kern_valid = 1'b0;
            ecrc_q.push_back(c);
        end
        while (busy !== 1'b0) @(negedge ref_clk);
        repeat (64) @(negedge ref_clk);
    endtask : run_frame

    task automatic conclude();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude

    initial begin
        repeat (4) @(negedge ref_clk);
        chk("fv_rst", 16'(frame_valid), 16'h0000);
        chk("lv_rst", 16'(line_valid), 16'h0000);
        chk("busy_rst", 16'(busy), 16'h0000);
        rst_n = 1'b1;
        @(negedge ref_clk);
        chk("idle", 16'(pix_data), 16'(ppf_pkg::TRAIN_RST));
        $display("test reset done");
        geom = '{11'h000, 11'h001, 11'h001, 11'h002};
        win_b_en = 1'b1;
        for (int m = 0; m < 3; m++) begin
            sub_mode = ppf_pkg::ppf_sub_t'(m);
            crc_seed_ones = m[0];
            run_frame(3, 10);
            chk("npix", 16'(ppf_rx_model_inst.pix_q.size()),
                16'(exp_q.size()));
            foreach (exp_q[i]) chk("pix", 16'(ppf_rx_model_inst.pix_q[i]),
                16'(exp_q[i]));
            foreach (ecrc_q[i]) chk("crc", 16'(ppf_rx_model_inst.crc_q[i]),
                16'(ecrc_q[i]));
            $display("test order %0d done", m);
        end
        chk("full", 16'(refused), 16'h0001);
        geom = '0;
        win_b_en = 1'b0;
        black_rows = 11'h001;
        sub_mode = ppf_pkg::SUB_NONE;
        for (int e = 0; e < 4; e++) begin
            {black_row_frame_strobe_en, black_row_line_strobe_en} = e[1:0];
            run_frame(2, 1);
            chk("fv_n", 16'(ppf_rx_model_inst.fv_n),
                e[1] ? 16'h0016 : 16'h000A);
            chk("lv_n", 16'(ppf_rx_model_inst.lv_n),
                e[0] ? 16'h0010 : 16'h0008);
            chk("bcrc", 16'(ppf_rx_model_inst.crc_q[$]),
                16'(ecrc_q[1]));
            $display("test black %0d done", e);
        end
        train_word = 10'h155;
        train_wr = 1'b1;
        @(negedge ref_clk);
        train_wr = 1'b0;
        repeat (64) @(negedge ref_clk);
        chk("train", 16'(pix_data), 16'h0155);
        $display("test train done");
        conclude();
    end
endmodule : parallel_pixel_frame_output_test
`default_nettype wire
